// ### verilog/ddr2_seq_defines.svh
// timing, field and offset constants for the ddr2 command sequencer
// Function
// - no burst interrupt with burst length 4
// - read burst interrupted only by a read
// - write burst interrupted only by a write
// - read interrupt exactly two clocks after read
// - write interrupt exactly two clocks after write
// - interrupt may address any bank
// - auto-precharge bursts are never interrupted
// - interrupt may itself carry auto-precharge
// - spacings follow programmed burst, not actual burst
// - a10 high closes all, else ba selects bank
// - read to precharge: al+bl/2+max(rtp,2)-2
// - precharge after tras, activate after trp
// - read to precharge also meets trtp
// - write to precharge: wl+bl/2+twr
// - a10 on read/write selects auto-precharge
// - read auto-precharge starts al+bl/2 after command
// - auto-precharge waits for tras and trtp
// - trp starts where trtp ends
// - precharge never before two clocks after prefetch
// - reactivate after trp and trc both
// - write auto-precharge after wr, reactivate after wr+trp
// - tras lockout delays any auto-precharge
// - rl is al+cl, wl is rl minus one
// - burst length from mode register bits 2..0
`ifndef DDR2_SEQ_DEFINES_SVH
`define DDR2_SEQ_DEFINES_SVH

// ==========================================
// clock and analog times in picoseconds
`define TCK_PS 4000
`define TRAS_PS 45000
`define TRP_PS 15000
`define TRC_PS 60000
`define TRTP_PS 7500
`define TWR_PS 15000
`define RU_CYC(t) (((t) + `TCK_PS - 1) / `TCK_PS)

// ==========================================
// cycle counts, least times rounded up
`define TRAS_CYC 6'(`RU_CYC(`TRAS_PS))
`define TRP_CYC 6'(`RU_CYC(`TRP_PS))
`define TRC_CYC 6'(`RU_CYC(`TRC_PS))
`define RTP_CYC 6'(`RU_CYC(`TRTP_PS))
`define WR_CYC 6'(`RU_CYC(`TWR_PS))
`define RTPRP_CYC 6'(`RU_CYC(`TRTP_PS + `TRP_PS))
`define AL_CYC 6'h00
`define CL_CYC 6'h03
`define TCCD_CYC 6'h02
`define INT_GAP 6'h02
`define AGE_MAX 6'h3F

// ==========================================
// address fields on the link
`define AP_BIT 10
`define BL_LSB 0
`define BL_MSB 2
`define BL8_CODE 3'h3

// ==========================================
// register offsets and command word fields
`define CMD_OFS 12'h000
`define STAT_OFS 12'h004
`define OP_LSB 0
`define OP_MSB 2
`define BANK_LSB 4
`define BANK_MSB 5
`define ADDR_LSB 16
`define ADDR_MSB 28

`endif

// ### verilog/ddr2_seq_pkg.sv
// types shared by both ends of the ddr2 command link
package ddr2_seq_pkg;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3,
    CMD_PRE = 3'h4,
    CMD_MRS = 3'h5
  } cmd_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_WAIT = 2'h2
  } ctrl_state_e;

  typedef logic [5:0] cnt_t;

  // larger of two cycle counts
  function automatic cnt_t cmax(input cnt_t a, input cnt_t b);
    return (a > b) ? a : b;
  endfunction : cmax

endpackage : ddr2_seq_pkg

// ### verilog/ddr2_cmd_if.sv
// command link between controller and ddr2 device
`timescale 1ns/100ps
interface ddr2_cmd_if;
  import ddr2_seq_pkg::*;
  cmd_e cmd;
  logic [1:0] bank;
  logic [12:0] addr;
  modport ctrl (output cmd, output bank, output addr);
  modport dev (input cmd, input bank, input addr);
endinterface : ddr2_cmd_if

// ### verilog/ddr2_cmd_device.sv
// ddr2 device end: burst tracking, bank precharge and auto-precharge
`timescale 1ns/100ps
`include "ddr2_seq_defines.svh"
module ddr2_cmd_device import ddr2_seq_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  ddr2_cmd_if.dev link,
  input wire logic errorClear,
  output logic [3:0] bankOpen,
  output logic [3:0] apStart,
  output logic burstLen8,
  output logic burstBusy,
  output logic cmdError
);

  logic bl8_r, burstRd_r, burstAp_r, busy_r, err_r, isCas, isRd, ap, badInt;
  cnt_t burstLeft_r, casAge_r, halfBl, rdAp, rdRtp, wrAp;

  assign isRd = link.cmd == CMD_RD;
  assign isCas = isRd || link.cmd == CMD_WR;
  assign ap = link.addr[`AP_BIT];
  assign halfBl = bl8_r ? 6'h04 : 6'h02;
  assign rdAp = `AL_CYC + halfBl - 6'h01;
  assign rdRtp = `AL_CYC + (bl8_r ? 6'h02 : 6'h00) + cmax(`RTP_CYC, 6'h02) - 6'h01;
  assign wrAp = (`AL_CYC + `CL_CYC - 6'h01) + halfBl + `WR_CYC - 6'h01;

  // ==========================================
  // mode register burst length
  always_ff @(posedge clock) begin
    if (reset) begin
      bl8_r <= 1'b0;
    end else if (clockEnable && link.cmd == CMD_MRS) begin
      bl8_r <= link.addr[`BL_MSB:`BL_LSB] == `BL8_CODE;
    end
  end

  // ==========================================
  // programmed burst window; a new cas restarts it on any bank
  always_ff @(posedge clock) begin
    if (reset) begin
      burstLeft_r <= 6'h00;
      casAge_r <= `AGE_MAX;
      burstRd_r <= 1'b0;
      burstAp_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (clockEnable) begin
      if (isCas) begin
        burstLeft_r <= halfBl - 6'h01;
        casAge_r <= 6'h01;
        burstRd_r <= isRd;
        burstAp_r <= ap;
        busy_r <= 1'b1;
      end else begin
        if (burstLeft_r != 6'h00) begin
          burstLeft_r <= burstLeft_r - 6'h01;
        end
        if (casAge_r != `AGE_MAX) begin
          casAge_r <= casAge_r + 6'h01;
        end
        busy_r <= burstLeft_r > 6'h01;
      end
    end
  end

  // flags an interrupt that the controller should not have sent
  assign badInt = burstLeft_r != 6'h00 && (link.cmd == CMD_PRE || (isCas &&
    !(bl8_r && !burstAp_r && casAge_r == `INT_GAP && isRd == burstRd_r)));

  // sticky error, a new error wins over the clear
  always_ff @(posedge clock) begin
    if (reset) begin
      err_r <= 1'b0;
    end else if (clockEnable) begin
      err_r <= badInt || (err_r && !errorClear);
    end
  end

  assign burstLen8 = bl8_r;
  assign burstBusy = busy_r;
  assign cmdError = err_r;

  // ==========================================
  // per bank row state and auto-precharge timing
  generate
    for (genvar b = 0; b < 4; b++) begin : g_bank
      cnt_t rasAge_r, apWait_r, rtpWait_r;
      logic open_r, apPend_r, apPulse_r, hit, fire;
      assign hit = link.bank == 2'(b);
      // fires when the base edge, trtp and tras are all met
      assign fire = apPend_r && apWait_r == 6'h00 && rtpWait_r == 6'h00
        && rasAge_r >= `TRAS_CYC;
      assign bankOpen[b] = open_r;
      assign apStart[b] = apPulse_r;
      always_ff @(posedge clock) begin
        if (reset) begin
          open_r <= 1'b0;
          apPend_r <= 1'b0;
          apPulse_r <= 1'b0;
          rasAge_r <= `AGE_MAX;
          apWait_r <= 6'h00;
          rtpWait_r <= 6'h00;
        end else if (clockEnable) begin
          apPulse_r <= fire;
          if (apWait_r != 6'h00) begin
            apWait_r <= apWait_r - 6'h01;
          end
          if (rtpWait_r != 6'h00) begin
            rtpWait_r <= rtpWait_r - 6'h01;
          end
          if (rasAge_r != `AGE_MAX) begin
            rasAge_r <= rasAge_r + 6'h01;
          end
          if (fire) begin
            open_r <= 1'b0;
            apPend_r <= 1'b0;
          end
          if (link.cmd == CMD_ACT && hit) begin
            open_r <= 1'b1;
            rasAge_r <= 6'h01;
          end
          if (link.cmd == CMD_PRE && (ap || hit)) begin
            open_r <= 1'b0;
            apPend_r <= 1'b0;
          end
          if (isCas && hit) begin
            apPend_r <= ap;
            apWait_r <= isRd ? rdAp : wrAp;
            rtpWait_r <= isRd ? rdRtp : 6'h00;
          end
        end
      end
    end
  endgenerate

endmodule : ddr2_cmd_device

// ### verilog/ddr2_cmd_ctrl.sv
// apb controlled ddr2 command issuer that keeps burst and precharge spacing
`timescale 1ns/100ps
`include "ddr2_seq_defines.svh"
module ddr2_cmd_ctrl import ddr2_seq_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ddr2_cmd_if.ctrl link
);

  ctrl_state_e state_r;
  cmd_e reqOp_r;
  cmd_e cmd_r;
  logic [1:0] reqBank_r;
  logic [1:0] bank_r;
  logic [12:0] reqAddr_r;
  logic [12:0] addr_r;
  logic [31:0] prdata_r;
  logic [31:0] status;
  logic pready_r, pslverr_r;
  logic bl8_r, lastRd_r, lastAp_r;
  logic access, cmdHit, statHit, cmdWrite;
  logic reqAp, reqRd, isCas, canInt, legal, issue;
  logic [3:0] openVec, preRdy, actRdy;
  cnt_t burstLeft_r, casAge_r, halfBl, wlCyc;
  cnt_t rdPre, rdApAct, wrPre, wrApAct;

  // ==========================================
  // apb slave
  assign access = psel && penable && !pready_r;
  assign cmdHit = paddr == `CMD_OFS;
  assign statHit = paddr == `STAT_OFS;
  assign cmdWrite = access && pwrite && cmdHit;
  assign status = {24'h000000, openVec, 1'b0, burstLeft_r != 6'h00, bl8_r,
    state_r == ST_WAIT};

  // answer one cycle into access, command write held while one is pending
  always_ff @(posedge clock) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (clockEnable) begin
      pready_r <= access && !(cmdWrite && state_r != ST_IDLE);
      pslverr_r <= access && !cmdHit && !statHit;
      prdata_r <= (access && !pwrite && statHit) ? status : 32'h00000000;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // ==========================================
  // request state machine
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= ST_IDLE;
      reqOp_r <= CMD_NOP;
      reqBank_r <= 2'h0;
      reqAddr_r <= 13'h0000;
    end else if (clockEnable) begin
      case (state_r)
        ST_IDLE: begin
          if (cmdWrite) begin
            state_r <= ST_WAIT;
            reqOp_r <= cmd_e'(pwdata[`OP_MSB:`OP_LSB]);
            reqBank_r <= pwdata[`BANK_MSB:`BANK_LSB];
            reqAddr_r <= pwdata[`ADDR_MSB:`ADDR_LSB];
          end
        end
        ST_WAIT: begin
          if (legal) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign issue = state_r == ST_WAIT && legal;

  // ==========================================
  // spacing figures derived from the programmed burst length
  assign halfBl = bl8_r ? 6'h04 : 6'h02;
  assign wlCyc = `AL_CYC + `CL_CYC - 6'h01;
  // al+bl/2+max(rtp,2)-2, less one for the countdown
  assign rdPre = `AL_CYC + halfBl + cmax(`RTP_CYC, 6'h02) - 6'h03;
  assign rdApAct = cmax(`AL_CYC + (bl8_r ? 6'h02 : 6'h00) + `RTPRP_CYC - 6'h01,
    `AL_CYC + halfBl + `TRP_CYC - 6'h01);
  assign wrPre = wlCyc + halfBl + `WR_CYC - 6'h01;
  assign wrApAct = wrPre + `TRP_CYC;

  // ==========================================
  // legality of the pending request
  assign reqAp = reqAddr_r[`AP_BIT];
  assign reqRd = reqOp_r == CMD_RD;
  assign isCas = reqRd || reqOp_r == CMD_WR;
  // only bl8, same kind, exactly two clocks, and no auto-precharge burst
  assign canInt = bl8_r && !lastAp_r && casAge_r == `INT_GAP
    && reqRd == lastRd_r;

  always_comb begin
    case (reqOp_r)
      CMD_RD, CMD_WR: begin
        legal = openVec[reqBank_r] && ((burstLeft_r == 6'h00) ?
          casAge_r >= `TCCD_CYC : canInt);
      end
      CMD_PRE: begin
        // no precharge inside a burst window
        legal = burstLeft_r == 6'h00 && (reqAp ? &preRdy : preRdy[reqBank_r]);
      end
      CMD_ACT: begin
        legal = actRdy[reqBank_r];
      end
      CMD_MRS: begin
        legal = burstLeft_r == 6'h00 && openVec == 4'h0;
      end
      default: begin
        legal = 1'b1;
      end
    endcase
  end

  // ==========================================
  // command output, one cycle per issued command
  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_r <= CMD_NOP;
      bank_r <= 2'h0;
      addr_r <= 13'h0000;
    end else if (clockEnable) begin
      cmd_r <= issue ? reqOp_r : CMD_NOP;
      if (issue) begin
        bank_r <= reqBank_r;
        addr_r <= reqAddr_r;
      end
    end
  end

  assign link.cmd = cmd_r;
  assign link.bank = bank_r;
  assign link.addr = addr_r;

  // ==========================================
  // burst window, cas age and mode tracking
  always_ff @(posedge clock) begin
    if (reset) begin
      burstLeft_r <= 6'h00;
      casAge_r <= `AGE_MAX;
      lastRd_r <= 1'b0;
      lastAp_r <= 1'b0;
      bl8_r <= 1'b0;
    end else if (clockEnable) begin
      if (issue && isCas) begin
        burstLeft_r <= halfBl - 6'h01;
        casAge_r <= 6'h01;
        lastRd_r <= reqRd;
        lastAp_r <= reqAp;
      end else begin
        if (burstLeft_r != 6'h00) begin
          burstLeft_r <= burstLeft_r - 6'h01;
        end
        if (casAge_r != `AGE_MAX) begin
          casAge_r <= casAge_r + 6'h01;
        end
      end
      if (issue && reqOp_r == CMD_MRS) begin
        bl8_r <= reqAddr_r[`BL_MSB:`BL_LSB] == `BL8_CODE;
      end
    end
  end

  // ==========================================
  // per bank precharge and activate countdowns
  generate
    for (genvar b = 0; b < 4; b++) begin : g_bank
      cnt_t preWait_r, actWait_r, preCur, actCur;
      logic open_r, hit;
      assign hit = issue && reqBank_r == 2'(b);
      assign preCur = (preWait_r == 6'h00) ? 6'h00 : preWait_r - 6'h01;
      assign actCur = (actWait_r == 6'h00) ? 6'h00 : actWait_r - 6'h01;
      assign preRdy[b] = preWait_r == 6'h00;
      assign actRdy[b] = actWait_r == 6'h00 && !open_r;
      assign openVec[b] = open_r;
      always_ff @(posedge clock) begin
        if (reset) begin
          open_r <= 1'b0;
          preWait_r <= 6'h00;
          actWait_r <= 6'h00;
        end else if (clockEnable) begin
          preWait_r <= preCur;
          actWait_r <= actCur;
          if (hit && reqOp_r == CMD_ACT) begin
            open_r <= 1'b1;
            preWait_r <= `TRAS_CYC - 6'h01;
            actWait_r <= `TRC_CYC - 6'h01;
          end
          if (hit && reqOp_r == CMD_RD) begin
            preWait_r <= cmax(preCur, rdPre);
            if (reqAp) begin
              open_r <= 1'b0;
              actWait_r <= cmax(actCur, rdApAct);
            end
          end
          if (hit && reqOp_r == CMD_WR) begin
            preWait_r <= cmax(preCur, wrPre);
            if (reqAp) begin
              open_r <= 1'b0;
              actWait_r <= cmax(actCur, wrApAct);
            end
          end
          if (issue && reqOp_r == CMD_PRE && (reqAp || reqBank_r == 2'(b))) begin
            open_r <= 1'b0;
            actWait_r <= cmax(actCur, `TRP_CYC - 6'h01);
          end
        end
      end
    end
  endgenerate

endmodule : ddr2_cmd_ctrl

// ### test/ddr2_cmd_link_monitor.sv
// link checker: burst interrupt and precharge spacing kept by the controller
`timescale 1ns/100ps
`include "ddr2_seq_defines.svh"
module ddr2_cmd_link_monitor import ddr2_seq_pkg::*; (
  input logic clock,
  input logic reset,
  input cmd_e cmd,
  input logic [1:0] bank,
  input logic [12:0] addr
);
  // ==========================================
  // helper state
  logic isCas;
  logic bl8_r;
  logic lastRd_r;
  logic [1:0] casBank_r;
  logic [3:0] apRd_r;
  cnt_t casAge_r;
  cnt_t actAge_r [4];
  cnt_t preAge_r [4];
  cnt_t apAge_r [4];
  cnt_t half;
  cnt_t rdPre;
  cnt_t wrPre;
  cnt_t rdAp1;
  cnt_t rdAp2;
  cnt_t apAct;

  function automatic cnt_t bump(input cnt_t a);
    return (a == `AGE_MAX) ? a : a + 6'h01;
  endfunction : bump

  // minimum spacings from programmed burst length
  assign isCas = (cmd == CMD_RD) || (cmd == CMD_WR);
  assign half = bl8_r ? 6'h04 : 6'h02;
  assign rdPre = `AL_CYC + half + ((`RTP_CYC > 6'h02) ? `RTP_CYC : 6'h02) - 6'h02;
  assign wrPre = `AL_CYC + `CL_CYC - 6'h01 + half + `WR_CYC;
  assign rdAp1 = `AL_CYC + (bl8_r ? 6'h02 : 6'h00) + `RTPRP_CYC;
  assign rdAp2 = `AL_CYC + half + `TRP_CYC;
  assign apAct = apRd_r[bank] ? ((rdAp1 > rdAp2) ? rdAp1 : rdAp2) : wrPre + `TRP_CYC;

  // mode and last column command
  always_ff @(posedge clock) begin
    if (reset) begin
      bl8_r <= 1'b0;
      lastRd_r <= 1'b0;
      casBank_r <= 2'h0;
      casAge_r <= `AGE_MAX;
    end else begin
      if (cmd == CMD_MRS) bl8_r <= (addr[`BL_MSB:`BL_LSB] == `BL8_CODE);
      if (isCas) begin
        lastRd_r <= (cmd == CMD_RD);
        casBank_r <= bank;
        casAge_r <= 6'h01;
      end else casAge_r <= bump(casAge_r);
    end
  end

  // per bank ages since activate, precharge and auto-precharge command
  always_ff @(posedge clock) begin
    for (int b = 0; b < 4; b++) begin
      if (reset) begin
        actAge_r[b] <= `AGE_MAX;
        preAge_r[b] <= `AGE_MAX;
        apAge_r[b] <= `AGE_MAX;
        apRd_r[b] <= 1'b0;
      end else begin
        actAge_r[b] <= (cmd == CMD_ACT && bank == 2'(b)) ? 6'h01 : bump(actAge_r[b]);
        preAge_r[b] <= (cmd == CMD_PRE && (addr[`AP_BIT] || bank == 2'(b))) ? 6'h01
                       : bump(preAge_r[b]);
        if (isCas && addr[`AP_BIT] && bank == 2'(b)) begin
          apAge_r[b] <= 6'h01;
          apRd_r[b] <= (cmd == CMD_RD);
        end else apAge_r[b] <= bump(apAge_r[b]);
      end
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_casGap;
    isCas |=> !isCas;
  endproperty
  a_casGap: assert property (p_casGap) else $error("column commands one cycle apart");
  property p_intGap;
    bl8_r && isCas |-> ##3 !isCas;
  endproperty
  a_intGap: assert property (p_intGap) else $error("interrupt not two cycles after");
  property p_sameKind;
    bl8_r && isCas |-> ##2 (!isCas || cmd == $past(cmd, 2));
  endproperty
  a_sameKind: assert property (p_sameKind) else $error("burst cut by other kind");
  property p_noApInt;
    bl8_r && isCas && addr[`AP_BIT] |-> ##2 !isCas;
  endproperty
  a_noApInt: assert property (p_noApInt) else $error("auto-precharge burst cut");
  property p_casPre;
    cmd == CMD_PRE && (addr[`AP_BIT] || bank == casBank_r)
      |-> casAge_r >= (lastRd_r ? rdPre : wrPre);
  endproperty
  a_casPre: assert property (p_casPre) else $error("precharge too soon");
  property p_tras;
    cmd == CMD_PRE && !addr[`AP_BIT] |-> actAge_r[bank] >= `TRAS_CYC;
  endproperty
  a_tras: assert property (p_tras) else $error("precharge before active time");
  property p_trp;
    cmd == CMD_ACT |-> preAge_r[bank] >= `TRP_CYC;
  endproperty
  a_trp: assert property (p_trp) else $error("activate before precharge time");
  property p_trc;
    cmd == CMD_ACT |-> actAge_r[bank] >= `TRC_CYC;
  endproperty
  a_trc: assert property (p_trc) else $error("activate before row cycle");
  property p_apAct;
    cmd == CMD_ACT |-> apAge_r[bank] >= apAct;
  endproperty
  a_apAct: assert property (p_apAct) else $error("activate too soon after auto");

  // main scenarios
  c_preAll: cover property (cmd == CMD_PRE && addr[`AP_BIT]);
  c_rdAp: cover property (bl8_r && cmd == CMD_RD && addr[`AP_BIT]);
  c_wrAp: cover property (cmd == CMD_WR && addr[`AP_BIT]);
  c_apAct: cover property (cmd == CMD_ACT && apAge_r[bank] != `AGE_MAX);
endmodule : ddr2_cmd_link_monitor

// ### test/ddr2_burst_interrupt_precharge_tb.sv
// testbench: apb driven controller facing a device, plus a hand driven device
`timescale 1ns/100ps
`include "ddr2_seq_defines.svh"
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (x)); end end
module ddr2_burst_interrupt_precharge_tb import ddr2_seq_pkg::*; ();
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic clockEnable = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, burstLen8, burstBusy, cmdError, badBl8, badBusy, badErr;
  logic errorClear = 1'b0;
  logic badClear = 1'b0;
  logic [3:0] bankOpen, apStart, badOpen, badAp;
  int errors = 0;
  int compares = 0;
  logic [3:0] apSeen = 4'h0;
  logic busySeen = 1'b0;
  ddr2_cmd_if link();
  ddr2_cmd_if badLink();

  always #2 clock = ~clock;

  // sticky record of the controller facing device pulses and levels
  always @(posedge clock) begin
    if (!reset) begin
      apSeen <= apSeen | apStart;
      busySeen <= busySeen | burstBusy;
    end
  end

  // ==========================================
  // design ends and checker
  ddr2_cmd_ctrl u_ddr2_cmd_ctrl (.clock, .reset, .clockEnable, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link.ctrl));
  ddr2_cmd_device u_ddr2_cmd_device (.clock, .reset, .clockEnable, .link(link.dev),
    .errorClear, .bankOpen, .apStart, .burstLen8, .burstBusy, .cmdError);
  ddr2_cmd_device u_ddr2_cmd_device_hand (.clock, .reset, .clockEnable, .link(badLink.dev),
    .errorClear(badClear), .bankOpen(badOpen), .apStart(badAp), .burstLen8(badBl8),
    .burstBusy(badBusy), .cmdError(badErr));
  ddr2_cmd_link_monitor u_ddr2_cmd_link_monitor (.clock, .reset, .cmd(link.cmd),
    .bank(link.bank), .addr(link.addr));

  // ==========================================
  // drivers
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic apbXfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                         output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apbXfer

  task automatic issue(input cmd_e op, input logic [1:0] b, input logic [12:0] a);
    logic [31:0] r;
    logic e;
    apbXfer(1'b1, `CMD_OFS, {3'h0, a, 10'h000, b, 1'b0, op}, r, e);
  endtask : issue

  task automatic waitIdle();
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apbXfer(1'b0, `STAT_OFS, 32'h0, r, e);
      n++;
    end while (r[0] !== 1'b0 && n < 200);
    if (r[0] !== 1'b0) errors++;
    repeat (3) @(posedge clock);
  endtask : waitIdle

  // one command on the hand driven link, sampled at the edge where this returns
  task automatic linkCmd(input cmd_e op, input logic [1:0] b, input logic [12:0] a);
    @(posedge clock);
    badLink.cmd <= op;
    badLink.bank <= b;
    badLink.addr <= a;
    @(posedge clock);
    badLink.cmd <= CMD_NOP;
  endtask : linkCmd

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle

  // ==========================================
  // scenarios
  task automatic testRegs();
    logic [31:0] r;
    logic e;
    apbXfer(1'b0, `STAT_OFS, 32'h0, r, e);
    `CHK(r, 32'h0)
    apbXfer(1'b0, 12'h008, 32'h0, r, e);
    `CHK(e, 1'b1)
    apbXfer(1'b0, `CMD_OFS, 32'h0, r, e);
    `CHK(r, 32'h0)
    $display("register test done");
  endtask : testRegs

  task automatic testBanks();
    for (int b = 0; b < 4; b++) issue(CMD_ACT, 2'(b), 13'h0000);
    waitIdle();
    `CHK(bankOpen, 4'hF)
    for (int b = 0; b < 4; b++) begin
      issue(CMD_PRE, 2'(b), 13'h0000);
      waitIdle();
      `CHK(bankOpen, 4'(4'hE << b))
    end
    issue(CMD_ACT, 2'h0, 13'h0000);
    issue(CMD_ACT, 2'h2, 13'h0000);
    issue(CMD_PRE, 2'h1, 13'h0400);
    waitIdle();
    `CHK(bankOpen, 4'h0)
    $display("bank test done");
  endtask : testBanks

  task automatic testBursts();
    cmd_e ops [10] = '{CMD_ACT, CMD_RD, CMD_RD, CMD_WR, CMD_RD, CMD_ACT, CMD_WR, CMD_ACT,
                       CMD_WR, CMD_PRE};
    logic [1:0] bks [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1};
    logic aps [10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [31:0] r;
    logic e;
    issue(CMD_MRS, 2'h0, 13'h0003);
    waitIdle();
    `CHK(burstLen8, 1'b1)
    apbXfer(1'b0, `STAT_OFS, 32'h0, r, e);
    `CHK(r[1], 1'b1)
    for (int i = 0; i < 10; i++) issue(ops[i], bks[i], aps[i] ? 13'h0400 : 13'h0000);
    waitIdle();
    idle(20);
    `CHK(bankOpen, 4'h0)
    `CHK(apSeen, 4'h1)
    `CHK(busySeen, 1'b1)
    `CHK(cmdError, 1'b0)
    $display("burst test done");
  endtask : testBursts

  task automatic testAutoPre();
    for (int m = 0; m < 2; m++) begin
      linkCmd(CMD_MRS, 2'h0, m ? 13'h0003 : 13'h0002);
      linkCmd(CMD_ACT, 2'h0, 13'h0000);
      idle(12);
      linkCmd(CMD_RD, 2'h0, 13'h0400);
      #1 `CHK(badBusy, 1'b1)
      idle(m ? 3 : 1);
      #1 `CHK(badAp, 4'h0)
      `CHK(badBusy, 1'b0)
      @(posedge clock);
      #1 `CHK(badAp, 4'h1)
      `CHK(badOpen, 4'h0)
      `CHK(badBl8, m[0])
      idle(8);
    end
    // a command seen while the clock enable is low must leave no trace
    clockEnable <= 1'b0;
    linkCmd(CMD_ACT, 2'h3, 13'h0000);
    idle(2);
    `CHK(badOpen, 4'h0)
    clockEnable <= 1'b1;
    linkCmd(CMD_ACT, 2'h3, 13'h0000);
    idle(2);
    `CHK(badOpen, 4'h8)
    linkCmd(CMD_PRE, 2'h3, 13'h0000);
    idle(4);
    $display("auto-precharge test done");
  endtask : testAutoPre

  task automatic testInterrupts();
    logic bl8s [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    cmd_e op2s [5] = '{CMD_RD, CMD_WR, CMD_RD, CMD_RD, CMD_PRE};
    logic [1:0] bk2s [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0};
    logic ap2s [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    int gaps [5] = '{2, 2, 3, 2, 2};
    logic exps [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      badClear <= 1'b1;
      @(posedge clock);
      badClear <= 1'b0;
      linkCmd(CMD_MRS, 2'h0, bl8s[i] ? 13'h0003 : 13'h0002);
      linkCmd(CMD_ACT, 2'h0, 13'h0000);
      linkCmd(CMD_ACT, 2'h1, 13'h0000);
      idle(12);
      linkCmd(CMD_RD, 2'h0, 13'h0000);
      idle(gaps[i] - 2);
      linkCmd(op2s[i], bk2s[i], ap2s[i] ? 13'h0400 : 13'h0000);
      idle(4);
      `CHK(badErr, exps[i])
      idle(12);
      linkCmd(CMD_PRE, 2'h0, 13'h0400);
      idle(8);
    end
    $display("interrupt test done");
  endtask : testInterrupts

  // ==========================================
  // main sequence and watchdog
  initial begin
    badLink.cmd = CMD_NOP;
    badLink.bank = 2'h0;
    badLink.addr = 13'h0000;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    testRegs();
    testBanks();
    testBursts();
    testAutoPre();
    testInterrupts();
    report_and_stop();
  end

  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule : ddr2_burst_interrupt_precharge_tb
